// ---- hdl/psl_strap_latch.v ----
// Purpose: latch power-up straps after reset release and apply software overrides
// Assumes: straps stable 10 clocks after system_reset_n rises; pads supply pull defaults
// Notes: pair index 0 is ports 0/1, index 1 is ports 6/7
// Behaviour
// - Straps latched at reset only; later pin changes ignored; overrides replace the rate, width, power-down and lane-order straps.
// - Width strap 0 gives 4x port; 1 gives two independent 1x ports.
// - Written MAC width field takes precedence over latched width strap.
// - Speed strap: 00 1.25G, 01 2.5G, 10 3.125G, 11 illegal.
// - Latched speed is initial line-rate field; writing it overrides.
// - Unconnected speed strap reads as pulled-up default, 3.125 Gbit/s.
// - Even power-down strap: 0 port n up, 1 powers down n and n+1.
// - Odd strap powers n+1 up at 0, down at 1; 4x forces n+1 down.
// - Wide and narrow power-down fields override even and odd straps.
// - Rx and tx swap straps: 0 order ABCD, 1 order DCBA.
// - Rx and tx lane-order fields override swap straps when written.
// - Multibyte strap high selects multi-byte addressing, low single-byte.
// - Target address straps give low two bits of own 7-bit address.
// - Address-source strap selects EEPROM low bits from straps, else 00.
// - Boot-inhibit 0 allows EEPROM load after reset; 1 stops it.
// - Initial width from straps; width override field may replace it later.
// - Reset active low, asynchronous assert, synchronised release.
`default_nettype none
`include "psl_consts.vh"
module psl_strap_latch #(
    parameter NP = `PSL_N_PAIRS
) (
    // Clock and reset
    input wire clk,
    input wire system_reset_n,
    // Strap pins
    input wire [1:0] line_rate_strap,
    input wire [NP-1:0] width_select_strap,
    input wire [NP-1:0] even_port_off_strap,
    input wire [NP-1:0] odd_port_off_strap,
    input wire rx_lane_order_strap,
    input wire tx_lane_order_strap,
    input wire multibyte_addr_strap,
    input wire [1:0] target_addr_low_straps,
    input wire eeprom_addr_src_strap,
    input wire boot_inhibit_strap,
    // Software override fields, each with a write strobe
    input wire line_rate_wr,
    input wire [1:0] line_rate_field,
    input wire [NP-1:0] mac_width_wr,
    input wire [NP-1:0] mac_width_field,
    input wire [NP-1:0] width_override_wr,
    input wire [NP-1:0] width_override_field,
    input wire [NP-1:0] wide_port_off_wr,
    input wire [NP-1:0] wide_port_off_field,
    input wire [NP-1:0] narrow_port_off_wr,
    input wire [NP-1:0] narrow_port_off_field,
    input wire rx_lane_order_wr,
    input wire rx_lane_order_field,
    input wire tx_lane_order_wr,
    input wire tx_lane_order_field,
    // Resulting settings
    output reg straps_valid,
    output reg [1:0] line_rate,
    output reg line_rate_illegal,
    output reg [NP-1:0] port_1x_mode,
    output reg [NP-1:0] even_port_off,
    output reg [NP-1:0] odd_port_off,
    output reg rx_lane_reverse,
    output reg tx_lane_reverse,
    output reg multibyte_addr,
    output reg [1:0] target_addr_low,
    output reg [1:0] eeprom_addr_low,
    output reg boot_load_enable
);
    localparam SW = 2 + 3 * NP + 7;
    localparam ST_WAIT = 1'b0;
    localparam ST_DONE = 1'b1;
    // Packed strap word, single-bit straps at the low end
    localparam P_INH = `PSL_POS_INH;
    localparam P_SEL = `PSL_POS_SEL;
    localparam P_SA = `PSL_POS_SA;
    localparam P_MB = `PSL_POS_MB;
    localparam P_TX = `PSL_POS_TX;
    localparam P_RX = `PSL_POS_RX;
    localparam P_ODD = `PSL_POS_ODD;
    localparam P_EVEN = P_ODD + NP;
    localparam P_WIDTH = P_EVEN + NP;
    localparam P_RATE = P_WIDTH + NP;
    localparam [`PSL_CNT_W-1:0] CNT_LAST = `PSL_STRAP_HOLD_CYCLES - 1'b1;

    // A written field replaces the strap until the next reset
    function pick1;
        input ov;
        input val;
        input strap;
        begin
            pick1 = ov ? val : strap;
        end
    endfunction

    function [1:0] pick2;
        input ov;
        input [1:0] val;
        input [1:0] strap;
        begin
            pick2 = ov ? val : strap;
        end
    endfunction

    // Odd port off on its own control, with its even port, or when the pair runs 4x
    function odd_off;
        input own;
        input even;
        input is_1x;
        begin
            odd_off = own | even | (is_1x == `PSL_WIDTH_4X);
        end
    endfunction

    // Boot address low bits follow the target straps only when selected
    function [1:0] boot_addr_low;
        input sel;
        input [1:0] sa;
        begin
            boot_addr_low = sel ? sa : `PSL_EEPROM_LOW_FORCED;
        end
    endfunction

    // Reset release through two flops
    reg rst_meta_q;
    reg rst_sync_q;
    always @(posedge clk or negedge system_reset_n) begin
        if (!system_reset_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    wire rst_n = rst_sync_q;

    // Straps are asynchronous pins
    wire [SW-1:0] pins_raw = {line_rate_strap, width_select_strap, even_port_off_strap,
        odd_port_off_strap, rx_lane_order_strap, tx_lane_order_strap, multibyte_addr_strap,
        target_addr_low_straps, eeprom_addr_src_strap, boot_inhibit_strap};
    wire [SW-1:0] pins_s;
    psl_sync2 #(.W(SW)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(pins_raw),
        .q(pins_s)
    );

    // Count ten cycles from release, then capture once
    reg state_q;
    reg [`PSL_CNT_W-1:0] cnt_q;
    reg [SW-1:0] cap_q;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_WAIT;
            cnt_q <= {`PSL_CNT_W{1'b0}};
            cap_q <= {SW{1'b0}};
        end else begin
            case (state_q)
                ST_WAIT: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == CNT_LAST) begin
                        cap_q <= pins_s;
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state_q <= ST_DONE; // Pins ignored until next reset
                end
                default: begin
                    state_q <= ST_WAIT;
                end
            endcase
        end
    end
    wire capture = (state_q == ST_WAIT) && (cnt_q == CNT_LAST);
    // Use freshly sampled pins in the capture cycle so outputs follow next edge
    wire [SW-1:0] src = capture ? pins_s : cap_q;

    wire [1:0] s_rate = src[P_RATE +: 2];
    wire [NP-1:0] s_width = src[P_WIDTH +: NP];
    wire [NP-1:0] s_even = src[P_EVEN +: NP];
    wire [NP-1:0] s_odd = src[P_ODD +: NP];
    wire s_rx = src[P_RX];
    wire s_tx = src[P_TX];
    wire s_mb = src[P_MB];
    wire [1:0] s_sa = src[P_SA +: 2];
    wire s_sel = src[P_SEL];
    wire s_inh = src[P_INH];

    // Override state: a written field replaces the strap until the next reset
    reg rate_ov_q;
    reg [1:0] rate_val_q;
    reg [NP-1:0] width_ov_q;
    reg [NP-1:0] width_val_q;
    reg [NP-1:0] wide_ov_q;
    reg [NP-1:0] wide_val_q;
    reg [NP-1:0] narrow_ov_q;
    reg [NP-1:0] narrow_val_q;
    reg rx_ov_q;
    reg rx_val_q;
    reg tx_ov_q;
    reg tx_val_q;
    integer i;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rate_ov_q <= 1'b0;
            rate_val_q <= `PSL_RATE_PULL_DEFAULT;
            width_ov_q <= {NP{1'b0}};
            width_val_q <= {NP{1'b0}};
            wide_ov_q <= {NP{1'b0}};
            wide_val_q <= {NP{1'b0}};
            narrow_ov_q <= {NP{1'b0}};
            narrow_val_q <= {NP{1'b0}};
            rx_ov_q <= 1'b0;
            rx_val_q <= 1'b0;
            tx_ov_q <= 1'b0;
            tx_val_q <= 1'b0;
        end else begin
            if (line_rate_wr) begin
                rate_ov_q <= 1'b1;
                rate_val_q <= line_rate_field;
            end
            for (i = 0; i < NP; i = i + 1) begin
                // MAC width field has priority over the port width override
                if (mac_width_wr[i]) begin
                    width_ov_q[i] <= 1'b1;
                    width_val_q[i] <= mac_width_field[i];
                end else if (width_override_wr[i]) begin
                    width_ov_q[i] <= 1'b1;
                    width_val_q[i] <= width_override_field[i];
                end
                if (wide_port_off_wr[i]) begin
                    wide_ov_q[i] <= 1'b1;
                    wide_val_q[i] <= wide_port_off_field[i];
                end
                if (narrow_port_off_wr[i]) begin
                    narrow_ov_q[i] <= 1'b1;
                    narrow_val_q[i] <= narrow_port_off_field[i];
                end
            end
            if (rx_lane_order_wr) begin
                rx_ov_q <= 1'b1;
                rx_val_q <= rx_lane_order_field;
            end
            if (tx_lane_order_wr) begin
                tx_ov_q <= 1'b1;
                tx_val_q <= tx_lane_order_field;
            end
        end
    end

    // Effective values, next cycle into output flops
    reg [1:0] rate_d;
    reg [NP-1:0] w1x_d;
    reg [NP-1:0] even_d;
    reg [NP-1:0] odd_d;
    integer k;
    always @* begin
        rate_d = pick2(rate_ov_q, rate_val_q, s_rate);
        for (k = 0; k < NP; k = k + 1) begin
            w1x_d[k] = pick1(width_ov_q[k], width_val_q[k], s_width[k]);
            even_d[k] = pick1(wide_ov_q[k], wide_val_q[k], s_even[k]);
            odd_d[k] = odd_off(pick1(narrow_ov_q[k], narrow_val_q[k], s_odd[k]), even_d[k], w1x_d[k]);
        end
    end

    // Outputs hold safe values until capture: all ports off, boot load withheld
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            straps_valid <= 1'b0;
            line_rate <= `PSL_RATE_PULL_DEFAULT;
            line_rate_illegal <= 1'b0;
            port_1x_mode <= {NP{1'b0}};
            even_port_off <= {NP{1'b1}};
            odd_port_off <= {NP{1'b1}};
            rx_lane_reverse <= 1'b0;
            tx_lane_reverse <= 1'b0;
            multibyte_addr <= 1'b0;
            target_addr_low <= 2'h0;
            eeprom_addr_low <= `PSL_EEPROM_LOW_FORCED;
            boot_load_enable <= 1'b0;
        end else if (capture || state_q == ST_DONE) begin
            straps_valid <= 1'b1;
            line_rate <= rate_d;
            line_rate_illegal <= (rate_d == `PSL_RATE_ILLEGAL);
            port_1x_mode <= w1x_d;
            even_port_off <= even_d;
            odd_port_off <= odd_d;
            rx_lane_reverse <= pick1(rx_ov_q, rx_val_q, s_rx);
            tx_lane_reverse <= pick1(tx_ov_q, tx_val_q, s_tx);
            multibyte_addr <= s_mb;
            target_addr_low <= s_sa;
            eeprom_addr_low <= boot_addr_low(s_sel, s_sa);
            boot_load_enable <= ~s_inh;
        end
    end
endmodule
`default_nettype wire

// ---- hdl/psl_consts.vh ----
// Purpose: constants for the power-up strap latch
// Assumes: 100 MHz core clock
// Notes: times in ns, counts given directly in clock cycles
`ifndef PSL_CONSTS_VH
`define PSL_CONSTS_VH
`define PSL_CLK_PERIOD_NS 10
`define PSL_STRAP_HOLD_CYCLES 4'hA
`define PSL_CNT_W 4
`define PSL_RATE_1G25 2'h0
`define PSL_RATE_2G5 2'h1
`define PSL_RATE_3G125 2'h2
`define PSL_RATE_ILLEGAL 2'h3
`define PSL_RATE_PULL_DEFAULT 2'h2
`define PSL_WIDTH_4X 1'h0
`define PSL_WIDTH_1X 1'h1
`define PSL_EEPROM_LOW_FORCED 2'h0
`define PSL_N_PAIRS 2
`define PSL_POS_INH 0
`define PSL_POS_SEL 1
`define PSL_POS_SA 2
`define PSL_POS_MB 4
`define PSL_POS_TX 5
`define PSL_POS_RX 6
`define PSL_POS_ODD 7
`endif

// ---- hdl/psl_sync2.v ----
// Purpose: two-flop synchroniser for asynchronous strap pins
// Assumes: pins are static levels
// Notes: first stage is read only by the second stage
`default_nettype none
module psl_sync2 #(
    parameter W = 1
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Data
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta_q;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ---- tb/psl_strap_latch_asserts.sv ----
// Purpose: port-level checks for the strap latch
// Assumes: bench writes no line rate before capture
// Notes: bound to the design in tb.sv
`default_nettype none
module psl_strap_latch_asserts #(
    parameter NP = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic system_reset_n,
    // Straps and writes
    input wire logic [1:0] line_rate_strap,
    input wire logic [1:0] target_addr_low_straps,
    input wire logic eeprom_addr_src_strap,
    input wire logic boot_inhibit_strap,
    input wire logic line_rate_wr,
    input wire logic [1:0] line_rate_field,
    // Settings
    input wire logic straps_valid,
    input wire logic [1:0] line_rate,
    input wire logic line_rate_illegal,
    input wire logic [NP-1:0] port_1x_mode,
    input wire logic [NP-1:0] even_port_off,
    input wire logic [NP-1:0] odd_port_off,
    input wire logic [1:0] target_addr_low,
    input wire logic [1:0] eeprom_addr_low,
    input wire logic boot_load_enable
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!system_reset_n);
    capture_time_a: assert property ($rose(system_reset_n) |-> ##11 !straps_valid ##1 straps_valid)
        else $error("capture edge wrong");
    valid_hold_a: assert property (straps_valid |=> straps_valid) else $error("valid dropped");
    illegal_flag_a: assert property (line_rate_illegal == (line_rate == 2'h3)) else $error("illegal flag");
    odd_off_a: assert property (straps_valid |-> ((even_port_off | ~port_1x_mode) & ~odd_port_off) == '0)
        else $error("odd port left on");
    rate_capture_a: assert property ($rose(straps_valid) |-> line_rate == $past(line_rate_strap, 3))
        else $error("rate not captured");
    eeprom_low_a: assert property ($rose(straps_valid) |-> eeprom_addr_low ==
        ($past(eeprom_addr_src_strap, 3) ? $past(target_addr_low_straps, 3) : 2'h0)) else $error("eeprom low bits");
    target_boot_a: assert property ($rose(straps_valid) |-> target_addr_low == $past(target_addr_low_straps, 3)
        && boot_load_enable != $past(boot_inhibit_strap, 3)) else $error("target or boot wrong");
    rate_write_a: assert property (line_rate_wr && straps_valid |-> ##2 line_rate == $past(line_rate_field, 2))
        else $error("rate write lost");
    pins_ignored_a: assert property (straps_valid ##1 $changed(line_rate) |-> $past(line_rate_wr, 2))
        else $error("rate moved without write");
    cover property ($rose(straps_valid));
    cover property (line_rate_illegal);
    cover property (line_rate_wr && straps_valid);
endmodule
`default_nettype wire

// ---- tb/psl_board_straps.sv ----
// Purpose: board strap pins behind the latch
// Assumes: cfg is set while reset is low
// Notes: pins wander once the sampling window is over
`default_nettype none
module psl_board_straps (
    // Clock and reset
    input wire logic clk,
    input wire logic system_reset_n,
    // Levels
    input wire logic [14:0] cfg,
    output logic [14:0] straps
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    int s = 38179;
    // Steady a few cycles past the ten required, then free to move
    always @(posedge clk) begin
        cnt <= !system_reset_n ? 0 : (cnt < 15) ? cnt + 1 : cnt;
        straps <= (cnt < 13) ? cfg : 15'($random(s));
    end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Purpose: self-checking bench for the strap latch
// Assumes: board model holds straps through sampling
// Notes: override state is mirrored here
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic system_reset_n = 1'b0;
    logic [14:0] cfg = 15'h0000;
    logic [10:0] wr = 11'h000;
    logic [11:0] fld = 12'h000;
    logic [1:0] r, w, e, d;
    logic rv, tv;
    wire [14:0] pin;
    wire [16:0] o;
    wire valid;
    int seed, t, j, b, k, n_mismatch, n_checks;
    always #5 clk = ~clk;
    psl_board_straps u_psl_board_straps (.clk(clk), .system_reset_n(system_reset_n), .cfg(cfg), .straps(pin));
    psl_strap_latch u_psl_strap_latch (
        .clk(clk), .system_reset_n(system_reset_n),
        .line_rate_strap(pin[14:13]), .width_select_strap(pin[12:11]), .even_port_off_strap(pin[10:9]),
        .odd_port_off_strap(pin[8:7]), .rx_lane_order_strap(pin[6]), .tx_lane_order_strap(pin[5]),
        .multibyte_addr_strap(pin[4]), .target_addr_low_straps(pin[3:2]), .eeprom_addr_src_strap(pin[1]),
        .boot_inhibit_strap(pin[0]), .line_rate_wr(wr[0]), .line_rate_field(fld[1:0]), .mac_width_wr(wr[2:1]),
        .mac_width_field(fld[3:2]), .width_override_wr(wr[4:3]), .width_override_field(fld[5:4]),
        .wide_port_off_wr(wr[6:5]), .wide_port_off_field(fld[7:6]), .narrow_port_off_wr(wr[8:7]),
        .narrow_port_off_field(fld[9:8]), .rx_lane_order_wr(wr[9]), .rx_lane_order_field(fld[10]),
        .tx_lane_order_wr(wr[10]), .tx_lane_order_field(fld[11]), .straps_valid(valid), .line_rate(o[16:15]),
        .line_rate_illegal(o[14]), .port_1x_mode(o[13:12]), .even_port_off(o[11:10]), .odd_port_off(o[9:8]),
        .rx_lane_reverse(o[7]), .tx_lane_reverse(o[6]), .multibyte_addr(o[5]), .target_addr_low(o[4:3]),
        .eeprom_addr_low(o[2:1]), .boot_load_enable(o[0])
    );
    function automatic logic [16:0] expv();
        return {r, r == 2'h3, w, e, d | e | ~w, rv, tv, cfg[4], cfg[3:2], cfg[1] ? cfg[3:2] : 2'h0, ~cfg[0]};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        seed = 38179;
        for (t = 0; t < 10; t++) begin
            system_reset_n = 1'b0;
            cfg = (t == 4) ? 15'h7FFF : (t == 5) ? 15'h0000 : 15'($random(seed));
            if (t < 4)
                cfg[14:13] = t[1:0];
            tick(3);
            chk("reset", 18'h10F00, {valid, o});
            system_reset_n = 1'b1;
            k = 0;
            while (valid !== 1'b1 && k < 30) begin
                tick(1);
                k++;
            end
            if (k >= 30) begin
                n_mismatch++;
                results();
            end
            chk("latency", 18'd12, 18'(k));
            {r, w, e, d, rv, tv} = cfg[14:5];
            chk("capture", {1'b1, expv()}, {valid, o});
            tick(8);
            chk("pins ignored", {1'b1, expv()}, {valid, o});
            for (j = 0; j < 4; j++) begin
                wr = (j == 0) ? 11'h7FF : 11'($random(seed));
                fld = 12'($random(seed));
                if (wr[0])
                    r = fld[1:0];
                for (b = 0; b < 2; b++) begin
                    if (wr[1+b])
                        w[b] = fld[2+b];
                    else if (wr[3+b])
                        w[b] = fld[4+b];
                    if (wr[5+b])
                        e[b] = fld[6+b];
                    if (wr[7+b])
                        d[b] = fld[8+b];
                end
                if (wr[9])
                    rv = fld[10];
                if (wr[10])
                    tv = fld[11];
                tick(1);
                wr = 11'h000;
                tick(1);
                chk("override", {1'b1, expv()}, {valid, o});
            end
            $display("test %0d done", t);
        end
        results();
    end
endmodule
bind psl_strap_latch psl_strap_latch_asserts #(.NP(NP)) u_psl_strap_latch_asserts (
    .clk, .system_reset_n, .line_rate_strap, .target_addr_low_straps, .eeprom_addr_src_strap,
    .boot_inhibit_strap, .line_rate_wr, .line_rate_field, .straps_valid, .line_rate, .line_rate_illegal,
    .port_1x_mode, .even_port_off, .odd_port_off, .target_addr_low, .eeprom_addr_low, .boot_load_enable
);
`default_nettype wire
